// ### verilog/acs_scanner.sv
// Purpose: Channel scanner and result store for an 8-channel multiplexed 12-bit ADC
// Assumes: APB3 slave, zero wait states, converter answers with a done pulse
// Notes: Conversion timeout bounds each slot so a full scan fits a servo period
// Function
// [R1] One shared 12-bit converter, eight channels
// [R2] Four ranges per channel, two bipolar
// [R3] Bipolar signed, unipolar unsigned results
// [R4] Channels one to four are external
// [R5] Upper four channels are internal test points
// [R6] Per channel feedback, software, or both
// [R7] Software reads any channel's latest result
// [R8] Any channel feeds any axis
// [R9] Feedback value is absolute position
// [R10] Per channel enable gates the scan
// [R11] Software should disable unused channels
// [R12] Feedback refreshed every servo period
// [R13] Servo period is 62.5 microseconds
// [R14] Ascending scan, wrap, idle when none
// [R15] Results update atomically
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_scanner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output acs_pkg::acs_conv_req_type conv_req,
	input wire acs_pkg::acs_conv_rsp_type conv_rsp,
	output acs_pkg::acs_fb_type [3:0] fb_out
);
	localparam int ACS_SET_LIM = `ACS_SETTLE_CYC;
	localparam int ACS_TMO_LIM = `ACS_CONV_TMO_CYC + 1;
	localparam logic [10:0] ACS_SERVO_CNT = 11'(`ACS_SERVO_CYC);
	localparam logic [7:0] ACS_SET_CNT = 8'(`ACS_SETTLE_CYC - 1);
	localparam logic [7:0] ACS_TMO_CNT = 8'(`ACS_CONV_TMO_CYC);

	// Software registers
	logic [7:0] chan_en_reg; // Scan enables
	logic [15:0] range_reg; // Two range bits per channel
	logic [15:0] mode_reg; // Feedback low byte, software high byte
	logic [15:0] axis_map_reg; // Four axis selectors
	logic tmo_reg; // Sticky converter timeout
	logic [15:0] scan_cnt_reg; // Completed scan passes
	// Bus answer
	logic [31:0] prdata_reg;
	logic err_reg;
	logic [31:0] rd_data;
	logic rd_hit;
	// Sequencer
	acs_pkg::acs_state_type state_reg;
	logic [2:0] ch_reg; // Channel on the multiplexer
	logic [1:0] rng_reg; // Range latched for this slot
	logic [7:0] cnt_reg; // Settle and timeout counter
	logic got_reg; // Slot produced a fresh result
	logic start_reg; // One-cycle start to converter
	acs_pkg::acs_result_type [7:0] result_reg;
	logic [10:0] age_reg [8]; // Cycles since each channel refreshed
	logic [7:0] stale; // Feedback channel missed a servo period
	logic [7:0] en_d_reg; // Enables one cycle back, for checks
	// Next channel search
	logic [2:0] search_start;
	logic nxt_found;
	logic [2:0] nxt_ch;
	logic store;
	logic wr;
	logic [15:0] cur_val;
	logic [15:0] rd_fmt; // Formatted result at the read index, kept apart for sign extension

	// Range bits of one channel
	function automatic logic [1:0] range_of(input logic [15:0] r, input logic [2:0] c);
		range_of = r[2*c +: 2];
	endfunction : range_of

	// Result window index from a byte address
	function automatic logic [2:0] result_idx(input logic [11:0] a);
		result_idx = a[4:2];
	endfunction : result_idx

	// Zero wait states: answer in the first access cycle
	assign pready = psel & penable;
	assign pslverr = psel & penable & err_reg;
	assign prdata = prdata_reg;
	assign wr = psel & penable & pwrite;
	assign rd_fmt = acs_pkg::acs_format(result_reg[result_idx(paddr)]);

	// Read decode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (paddr == `ACS_OFF_CHAN_EN) begin
			rd_data = {24'h00_0000, chan_en_reg};
		end else if (paddr == `ACS_OFF_RANGE) begin
			rd_data = {16'h0000, range_reg};
		end else if (paddr == `ACS_OFF_MODE) begin
			rd_data = {16'h0000, mode_reg};
		end else if (paddr == `ACS_OFF_AXIS_MAP) begin
			rd_data = {16'h0000, axis_map_reg};
		end else if (paddr == `ACS_OFF_STATUS) begin
			// [R4] external channel mask
			rd_data[`ACS_ST_EXT_LSB +: 8] = `ACS_EXT_CH_MASK;
			rd_data[`ACS_ST_TMO] = tmo_reg;
			rd_data[`ACS_ST_STALE_LSB +: 8] = stale;
			rd_data[`ACS_ST_BUSY] = (state_reg != acs_pkg::ACS_IDLE);
			rd_data[2:0] = ch_reg;
		end else if (paddr == `ACS_OFF_SCAN_CNT) begin
			rd_data = {16'h0000, scan_cnt_reg};
		end else if (paddr >= `ACS_OFF_RESULT0 && paddr <= `ACS_OFF_RESULT7) begin
			// [R7] software result read
			// [R6] software use gated by mode
			if (mode_reg[`ACS_MODE_SW_LSB + result_idx(paddr)]) begin
				rd_data = {{16{rd_fmt[15]}}, rd_fmt};
			end
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Capture read data in setup so the access phase sees flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (psel && !penable) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
			err_reg <= !rd_hit;
		end
	end

	// Control register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_en_reg <= `ACS_RST_CHAN_EN;
			range_reg <= `ACS_RST_RANGE;
			mode_reg <= `ACS_RST_MODE;
			axis_map_reg <= `ACS_RST_AXIS_MAP;
		end else if (wr) begin
			if (paddr == `ACS_OFF_CHAN_EN) begin
				// [R10] per channel enable
				chan_en_reg <= pwdata[7:0];
			end else if (paddr == `ACS_OFF_RANGE) begin
				// [R2] range select
				range_reg <= pwdata[15:0];
			end else if (paddr == `ACS_OFF_MODE) begin
				// [R6] usage per channel
				mode_reg <= pwdata[15:0];
			end else if (paddr == `ACS_OFF_AXIS_MAP) begin
				// [R8] axis source select
				axis_map_reg <= pwdata[15:0];
			end
		end
	end

	// Timeout flag: a new timeout beats a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_reg <= 1'b0;
		end else if (state_reg == acs_pkg::ACS_CONV && !conv_rsp.done && cnt_reg == ACS_TMO_CNT) begin
			tmo_reg <= 1'b1;
		end else if (wr && paddr == `ACS_OFF_STATUS && pwdata[`ACS_ST_TMO]) begin
			tmo_reg <= 1'b0;
		end
	end

	// [R14] ascending search, wraps
	assign search_start = (state_reg == acs_pkg::ACS_STORE) ? 3'(ch_reg + 3'h1) : ch_reg;
	acs_next_chan u_next (
		.en(chan_en_reg),
		.start(search_start),
		.found(nxt_found),
		.ch(nxt_ch)
	);

	// Scan sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= acs_pkg::ACS_IDLE;
			ch_reg <= 3'h0;
			rng_reg <= 2'h0;
			cnt_reg <= 8'h00;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			case (state_reg)
				acs_pkg::ACS_IDLE: begin
					// [R14] idle with nothing enabled
					if (nxt_found) begin
						ch_reg <= nxt_ch;
						rng_reg <= range_of(range_reg, nxt_ch);
						cnt_reg <= 8'h00;
						state_reg <= acs_pkg::ACS_SETTLE;
					end
				end
				acs_pkg::ACS_SETTLE: begin
					// Mux settles before the sample is taken
					if (cnt_reg == ACS_SET_CNT) begin
						cnt_reg <= 8'h00;
						start_reg <= 1'b1;
						state_reg <= acs_pkg::ACS_CONV;
					end else begin
						cnt_reg <= 8'(cnt_reg + 8'h01);
					end
				end
				acs_pkg::ACS_CONV: begin
					// [R12] bounded slot length
					if (conv_rsp.done || cnt_reg == ACS_TMO_CNT) begin
						state_reg <= acs_pkg::ACS_STORE;
					end else begin
						cnt_reg <= 8'(cnt_reg + 8'h01);
					end
				end
				acs_pkg::ACS_STORE: begin
					// [R10] only enabled channels visited
					if (nxt_found) begin
						ch_reg <= nxt_ch;
						rng_reg <= range_of(range_reg, nxt_ch);
						cnt_reg <= 8'h00;
						state_reg <= acs_pkg::ACS_SETTLE;
					end else begin
						state_reg <= acs_pkg::ACS_IDLE;
					end
				end
				default: begin
					state_reg <= acs_pkg::ACS_IDLE;
				end
			endcase
		end
	end

	// [R1] one converter, muxed channel
	// [R5] upper channels reached by mux
	assign conv_req.start = start_reg;
	assign conv_req.mux = ch_reg;
	assign conv_req.range = rng_reg;

	// [R15] code and range stored together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= '0;
			got_reg <= 1'b0;
		end else if (state_reg == acs_pkg::ACS_CONV && conv_rsp.done) begin
			result_reg[ch_reg] <= '{range: rng_reg, code: conv_rsp.data};
			got_reg <= 1'b1;
		end else if (state_reg == acs_pkg::ACS_STORE) begin
			got_reg <= 1'b0;
		end
	end

	// Scan pass counter bumps on wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_cnt_reg <= 16'h0000;
		end else if (state_reg == acs_pkg::ACS_STORE && nxt_found && nxt_ch <= ch_reg) begin
			scan_cnt_reg <= 16'(scan_cnt_reg + 16'h0001);
		end
	end

	assign store = (state_reg == acs_pkg::ACS_STORE) && got_reg;
	// [R3] encoding follows range
	assign cur_val = acs_pkg::acs_format(result_reg[ch_reg]);

	// [R13] servo period refresh watch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				age_reg[i] <= 11'h000;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (store && ch_reg == 3'(i)) begin
					age_reg[i] <= 11'h000;
				end else if (age_reg[i] != ACS_SERVO_CNT) begin
					age_reg[i] <= 11'(age_reg[i] + 11'h001);
				end
			end
		end
	end

	// [R12] stale feedback flags
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			stale[i] = chan_en_reg[i] && mode_reg[i] && (age_reg[i] == ACS_SERVO_CNT);
		end
	end

	// Enables one cycle back for the scan check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_d_reg <= 8'h00;
		end else begin
			en_d_reg <= chan_en_reg;
		end
	end

	// [R9] feedback to axes
	acs_axis_feed u_feed (
		.pclk(pclk),
		.presetn(presetn),
		.store(store),
		.store_ch(ch_reg),
		.store_val(cur_val),
		.fb_en(mode_reg[7:0]),
		.axis_map(axis_map_reg),
		.fb_out(fb_out)
	);

	// Checks
	property p_idle_none;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == acs_pkg::ACS_IDLE && chan_en_reg == 8'h00) |=> state_reg == acs_pkg::ACS_IDLE;
	endproperty
	a_idle_none: assert property (p_idle_none) else $error("scan left idle with none enabled"); // [R14]
	property p_enabled_only;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == acs_pkg::ACS_SETTLE) |-> en_d_reg[ch_reg];
	endproperty
	a_enabled_only: assert property (p_enabled_only) else $error("disabled channel scanned"); // [R10]
	property p_ascending;
		@(posedge pclk) disable iff (!presetn)
		($rose(state_reg == acs_pkg::ACS_SETTLE) && $past(state_reg) == acs_pkg::ACS_STORE)
			|-> (ch_reg > $past(ch_reg) || scan_cnt_reg != $past(scan_cnt_reg));
	endproperty
	a_ascending: assert property (p_ascending) else $error("scan not ascending"); // [R14]
	property p_start_once;
		@(posedge pclk) disable iff (!presetn)
		conv_req.start |-> (state_reg == acs_pkg::ACS_CONV && conv_req.mux == ch_reg) ##1 !conv_req.start;
	endproperty
	a_start_once: assert property (p_start_once) else $error("bad converter start"); // [R1]
	property p_settle_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == acs_pkg::ACS_SETTLE) |-> ##[ACS_SET_LIM:ACS_SET_LIM] conv_req.start;
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settle time wrong"); // [R12]
	property p_conv_bound;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == acs_pkg::ACS_CONV) |-> ##[1:ACS_TMO_LIM] state_reg == acs_pkg::ACS_STORE;
	endproperty
	a_conv_bound: assert property (p_conv_bound) else $error("conversion slot overran"); // [R12]
	property p_atomic;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == acs_pkg::ACS_CONV && conv_rsp.done)
			|=> result_reg[ch_reg] == {$past(rng_reg), $past(conv_rsp.data)};
	endproperty
	a_atomic: assert property (p_atomic) else $error("result not stored whole"); // [R15]
	property p_format;
		@(posedge pclk) disable iff (!presetn)
		store |-> (result_reg[ch_reg].range[1] ? cur_val[15:12] == 4'h0
			: (cur_val[15:11] == 5'h00 || cur_val[15:11] == 5'h1F));
	endproperty
	a_format: assert property (p_format) else $error("result encoding wrong"); // [R3]
	property p_age;
		@(posedge pclk) disable iff (!presetn)
		store |=> age_reg[$past(ch_reg)] == 11'h000;
	endproperty
	a_age: assert property (p_age) else $error("refresh age not cleared"); // [R13]
	c_wrap: cover property (@(posedge pclk) disable iff (!presetn) $changed(scan_cnt_reg));
	c_timeout: cover property (@(posedge pclk) disable iff (!presetn) $rose(tmo_reg));
	c_sw_read: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && paddr == `ACS_OFF_RESULT0);
endmodule : acs_scanner

// ### shared/acs_regs.svh
// Purpose: Register map, reset values, field positions and timing of the ADC scanner
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// Register byte offsets
`define ACS_OFF_CHAN_EN 12'h000
`define ACS_OFF_RANGE 12'h004
`define ACS_OFF_MODE 12'h008
`define ACS_OFF_AXIS_MAP 12'h00C
`define ACS_OFF_STATUS 12'h010
`define ACS_OFF_SCAN_CNT 12'h014
`define ACS_OFF_RESULT0 12'h040
`define ACS_OFF_RESULT7 12'h05C
// Reset values
`define ACS_RST_CHAN_EN 8'h00
`define ACS_RST_RANGE 16'h0000
`define ACS_RST_MODE 16'hFF00
`define ACS_RST_AXIS_MAP 16'h0000
// Field positions
`define ACS_MODE_SW_LSB 8
`define ACS_MAP_EN_BIT 3
`define ACS_ST_BUSY 3
`define ACS_ST_STALE_LSB 8
`define ACS_ST_TMO 16
`define ACS_ST_EXT_LSB 24
// Channels wired to connector pins, upper four are internal test points
`define ACS_EXT_CH_MASK 8'h0F
// Offset-binary to two's-complement flip
`define ACS_MSB_FLIP 12'h800
// Timing, figures in their own units
`define ACS_CLK_PERIOD_NS 50
`define ACS_SERVO_PERIOD_US 62.5
`define ACS_SETTLE_NS 1000
`define ACS_CONV_TMO_NS 5000
// Longest times round down, least times round up
`define ACS_SERVO_CYC ($rtoi((`ACS_SERVO_PERIOD_US * 1000.0) / `ACS_CLK_PERIOD_NS))
`define ACS_SETTLE_CYC ((`ACS_SETTLE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CONV_TMO_CYC (`ACS_CONV_TMO_NS / `ACS_CLK_PERIOD_NS)
`endif

// ### shared/acs_pkg.sv
// Purpose: Types and the result formatter shared by the scanner modules
// Assumes: Converter delivers straight binary codes 0 to 4095
// Notes: Nothing here is imported; users write acs_pkg::name
`include "acs_regs.svh"
package acs_pkg;
	// Input range per channel
	typedef enum logic [1:0] {
		ACS_RNG_BI10 = 2'h0,
		ACS_RNG_BI5 = 2'h1,
		ACS_RNG_UNI10 = 2'h2,
		ACS_RNG_UNI5 = 2'h3
	} acs_range_type;
	// Scan sequencer states, one-hot
	typedef enum logic [3:0] {
		ACS_IDLE = 4'h1,
		ACS_SETTLE = 4'h2,
		ACS_CONV = 4'h4,
		ACS_STORE = 4'h8
	} acs_state_type;
	// Request to the shared converter
	typedef struct packed {
		logic start;
		logic [2:0] mux;
		logic [1:0] range;
	} acs_conv_req_type;
	// Answer from the converter
	typedef struct packed {
		logic done;
		logic [11:0] data;
	} acs_conv_rsp_type;
	// One axis feedback word
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [15:0] pos;
	} acs_fb_type;
	// Stored result: range tag kept with the code so both change together
	typedef struct packed {
		logic [1:0] range;
		logic [11:0] code;
	} acs_result_type;
	// Bipolar ranges give signed values, unipolar unsigned, both widened to 16
	function automatic logic [15:0] acs_format(input acs_result_type r);
		logic [11:0] v;
		v = r.code;
		if (!r.range[1]) begin
			v = r.code ^ `ACS_MSB_FLIP;
			acs_format = {{4{v[11]}}, v};
		end else begin
			acs_format = {4'h0, v};
		end
	endfunction : acs_format
endpackage : acs_pkg

// ### verilog/acs_next_chan.sv
// Purpose: Pick the first enabled channel at or above a start index
// Assumes: Eight channels, wrap past the highest
// Notes: Pure combinational
`timescale 1ns/1ps
module acs_next_chan (
	input wire logic [7:0] en,
	input wire logic [2:0] start,
	output logic found,
	output logic [2:0] ch
);
	// Walk down so the nearest offset is the one that stays
	always_comb begin
		found = 1'b0;
		ch = start;
		for (int i = 7; i >= 0; i--) begin
			if (en[3'(start + 3'(i))]) begin
				found = 1'b1;
				ch = 3'(start + 3'(i));
			end
		end
	end
endmodule : acs_next_chan

// ### verilog/acs_axis_feed.sv
// Purpose: Route fresh channel results to the axes that use them as position
// Assumes: Four axes, each with a channel select and enable
// Notes: Outputs come from flip-flops
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_axis_feed (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic store,
	input wire logic [2:0] store_ch,
	input wire logic [15:0] store_val,
	input wire logic [7:0] fb_en,
	input wire logic [15:0] axis_map,
	output acs_pkg::acs_fb_type [3:0] fb_out
);
	acs_pkg::acs_fb_type [3:0] fb_reg; // Registered feedback per axis

	// [R8] any channel to any axis
	// [R9] position spans result range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_reg <= '0;
		end else begin
			for (int a = 0; a < 4; a++) begin
				fb_reg[a].valid <= 1'b0;
				// Whole word written in one edge, never torn
				if (store && fb_en[store_ch] && axis_map[4*a+`ACS_MAP_EN_BIT]
					&& axis_map[4*a +: 3] == store_ch) begin
					fb_reg[a].valid <= 1'b1;
					fb_reg[a].chan <= store_ch;
					fb_reg[a].pos <= store_val;
				end
			end
		end
	end
	assign fb_out = fb_reg;

	// [R9] feedback equals stored value
	property p_fb_value;
		@(posedge pclk) disable iff (!presetn)
		(store && fb_en[store_ch] && axis_map[`ACS_MAP_EN_BIT] && axis_map[2:0] == store_ch)
			|=> (fb_out[0].valid && fb_out[0].pos == $past(store_val));
	endproperty
	a_fb_value: assert property (p_fb_value) else $error("axis 0 feedback mismatch"); // [R9]
	// [R8] no feedback without a match
	property p_fb_gated;
		@(posedge pclk) disable iff (!presetn)
		fb_out[1].valid |-> ($past(store) && $past(axis_map[4+`ACS_MAP_EN_BIT])
			&& fb_out[1].chan == $past(axis_map[6:4]));
	endproperty
	a_fb_gated: assert property (p_fb_gated) else $error("axis 1 fed from wrong channel"); // [R8]
	c_fb_axis3: cover property (@(posedge pclk) disable iff (!presetn) fb_out[3].valid);
endmodule : acs_axis_feed

// ### bench/acs_conv_model.sv
// Purpose: Behavioural model of the shared converter behind the scanner
// Assumes: One request at a time; delay of 8'hFF means it never answers
// Notes: Data line toggles when no answer is due, so stale codes never look valid
`timescale 1ns/1ps
module acs_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire acs_pkg::acs_conv_req_type conv_req,
	input wire logic [7:0] delay,
	input wire logic [11:0] code,
	output acs_pkg::acs_conv_rsp_type conv_rsp
);
	logic [7:0] cnt_reg; // Cycles left before the answer
	logic busy_reg; // A conversion is pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			conv_rsp <= '0;
		end else begin
			conv_rsp.done <= 1'b0;
			// Released data line changes every cycle
			conv_rsp.data <= ~conv_rsp.data;
			if (conv_req.start && delay != 8'hFF) begin
				busy_reg <= 1'b1;
				cnt_reg <= delay;
			end else if (busy_reg && cnt_reg == 8'h00) begin
				// Answer pulse carries the code for one cycle
				busy_reg <= 1'b0;
				conv_rsp.done <= 1'b1;
				conv_rsp.data <= code;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
endmodule : acs_conv_model

// ### bench/test_adc_channel_scanner.sv
// Purpose: Self-checking bench for the ADC channel scanner
// Assumes: APB master with zero-delay tolerance, converter model as partner
// Notes: Table rows cover every range at boundary codes; awkward cases follow
`timescale 1ns/1ps
`include "acs_regs.svh"
module test_adc_channel_scanner;
	// One table row: channel, range, converter code, expected result word
	typedef struct {
		logic [2:0] ch;
		logic [1:0] rng;
		logic [11:0] code;
		logic [31:0] exp;
	} acs_row_type;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] delay = 8'h03; // Converter answer delay
	logic [11:0] code = 12'h000; // Code the converter returns
	logic [31:0] rq; // Last read word
	logic rerr; // Last error flag
	acs_pkg::acs_conv_req_type conv_req;
	acs_pkg::acs_conv_rsp_type conv_rsp;
	acs_pkg::acs_fb_type [3:0] fb_out;
	int n_errors = 0;
	int samples_checked = 0;
	logic [2:0] mux_log[$]; // Channel at each start pulse
	logic [2:0] ord[4] = '{3'h7, 3'h0, 3'h2, 3'h5}; // Scan resumes at the last channel used
	acs_row_type rows[7] = '{
		'{3'h0, 2'h0, 12'h000, 32'hFFFFF800}, '{3'h1, 2'h1, 12'hFFF, 32'h000007FF},
		'{3'h2, 2'h2, 12'hFFF, 32'h00000FFF}, '{3'h3, 2'h3, 12'h000, 32'h00000000},
		'{3'h4, 2'h0, 12'h800, 32'h00000000}, '{3'h6, 2'h1, 12'h7FF, 32'hFFFFFFFF},
		'{3'h7, 2'h2, 12'h7FF, 32'h000007FF}};
	acs_scanner u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_req(conv_req), .conv_rsp(conv_rsp), .fb_out(fb_out));
	acs_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
		.delay(delay), .code(code), .conv_rsp(conv_rsp));
	// Clock, 50 ns period
	initial begin
		forever #25 pclk = ~pclk;
	end
	// Record the channel of every start pulse at a settled time
	always @(negedge pclk) begin
		if (conv_req.start === 1'b1) begin
			mux_log.push_back(conv_req.mux);
		end
	end
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic fail();
		n_errors++;
		report_and_stop();
	endtask : fail
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rq = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 50) fail();
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(rq, exp);
	endtask : rdc
	// Poll until the scanner reports idle
	task automatic wait_idle();
		int i;
		rq = 32'hFFFFFFFF;
		for (i = 0; i < 100 && rq[`ACS_ST_BUSY] !== 1'b0; i++) rd(`ACS_OFF_STATUS);
		if (i == 100) fail();
	endtask : wait_idle
	task automatic wait_log(input int k);
		int i;
		for (i = 0; i < 4000 && mux_log.size() < k; i++) @(negedge pclk);
		if (mux_log.size() < k) fail();
	endtask : wait_log
	// Main sequence
	initial begin
		int i;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then an unmapped and a misaligned place
		rdc(`ACS_OFF_CHAN_EN, 32'h0);
		rdc(`ACS_OFF_RANGE, 32'h0);
		rdc(`ACS_OFF_MODE, 32'h0000FF00);
		rdc(`ACS_OFF_AXIS_MAP, 32'h0);
		rdc(`ACS_OFF_STATUS, 32'h0F000000);
		rdc(12'h020, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		rd(12'h002);
		chk({31'h0, rerr}, 32'h1);
		// Table: every range, boundary codes, external and internal channels
		foreach (rows[i]) begin
			code <= rows[i].code;
			wr(`ACS_OFF_RANGE, 32'(rows[i].rng) << (2 * rows[i].ch));
			mux_log.delete();
			wr(`ACS_OFF_CHAN_EN, 32'h1 << rows[i].ch);
			wait_log(2);
			wr(`ACS_OFF_CHAN_EN, 32'h0);
			wait_idle();
			chk({29'h0, mux_log[0]}, {29'h0, rows[i].ch});
			rdc(`ACS_OFF_RESULT0 + {7'h0, rows[i].ch, 2'h0}, rows[i].exp);
		end
		// Sparse enable set, ascending with wrap, starting where the last row stopped
		mux_log.delete();
		wr(`ACS_OFF_CHAN_EN, 32'hA5);
		wait_log(8);
		wr(`ACS_OFF_CHAN_EN, 32'h0);
		wait_idle();
		for (i = 0; i < 8; i++) chk({29'h0, mux_log[i]}, {29'h0, ord[i % 4]});
		// No channel enabled: no starts at all
		mux_log.delete();
		repeat (300) @(posedge pclk);
		chk(32'(mux_log.size()), 32'h0);
		// Internal channel as feedback of axis two
		code <= 12'h123;
		wr(`ACS_OFF_RANGE, 32'h00000C00);
		wr(`ACS_OFF_MODE, 32'h0000FF20);
		wr(`ACS_OFF_AXIS_MAP, 32'h00005DD8);
		wr(`ACS_OFF_CHAN_EN, 32'h20);
		for (i = 0; i < 400 && fb_out[2].valid !== 1'b1; i++) @(negedge pclk);
		if (i == 400) fail();
		chk({12'h0, fb_out[2]}, 32'h000D0123);
		chk({31'h0, fb_out[0].valid}, 32'h0);
		chk({12'h0, fb_out[1]}, 32'h000D0123);
		chk({31'h0, fb_out[3].valid}, 32'h0);
		chk({30'h0, conv_req.range}, 32'h3);
		rdc(`ACS_OFF_RESULT0 + 12'h014, 32'h123);
		wr(`ACS_OFF_MODE, 32'h00000020);
		rdc(`ACS_OFF_RESULT0 + 12'h014, 32'h0);
		// Converter silent: timeout flag, result kept whole
		wr(`ACS_OFF_MODE, 32'h0000FFFF);
		delay <= 8'hFF;
		// Let a conversion already in flight finish with the old code
		repeat (10) @(posedge pclk);
		code <= 12'hABC;
		rq = 32'h0;
		for (i = 0; i < 100 && rq[`ACS_ST_TMO] !== 1'b1; i++) rd(`ACS_OFF_STATUS);
		if (i == 100) fail();
		wr(`ACS_OFF_CHAN_EN, 32'h0);
		wait_idle();
		rdc(`ACS_OFF_RESULT0 + 12'h014, 32'h123);
		wr(`ACS_OFF_STATUS, 32'h00010000);
		rd(`ACS_OFF_STATUS);
		chk({31'h0, rq[`ACS_ST_TMO]}, 32'h0);
		// All eight channels, slow converter, every feedback kept fresh
		delay <= 8'h50;
		wr(`ACS_OFF_CHAN_EN, 32'hFF);
		repeat (3000) @(posedge pclk);
		rd(`ACS_OFF_STATUS);
		chk({24'h0, rq[15:8]}, 32'h0);
		rd(`ACS_OFF_SCAN_CNT);
		chk({31'h0, rq[15:0] >= 16'h0002}, 32'h1);
		// Reset in mid-scan clears requests and enables
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk({26'h0, conv_req}, 32'h0);
		chk({31'h0, fb_out[2].valid}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		rdc(`ACS_OFF_CHAN_EN, 32'h0);
		report_and_stop();
	end
endmodule : test_adc_channel_scanner
